// ===== pkg/reload_pwm_consts.svh
/*
  constants for the auto-reload pulse timer: word indices of the registers, field positions,
  reset values and timing counts.
  assumes a 32-bit bus with one register per aligned word.
*/
`ifndef RELOAD_PWM_CONSTS_SVH
`define RELOAD_PWM_CONSTS_SVH

// register indices as printed; the byte address is four times the index
`define IDX_CTRL_STATUS   8'h0d
`define IDX_COUNT_HIGH    8'h0e
`define IDX_COUNT_LOW     8'h0f
`define IDX_RELOAD_HIGH   8'h10
`define IDX_RELOAD_LOW    8'h11
`define IDX_OUT_CONTROL   8'h12
`define IDX_CHAN_STATUS   8'h13
`define IDX_DUTY_HIGH     8'h17
`define IDX_DUTY_LOW      8'h18
`define IDX_POWER_MODE    8'h1f

// field positions of timer_control_status
`define CS_COMPARE_IRQ_ENABLE_BIT      0
`define CS_OVERFLOW_IRQ_ENABLE_BIT      1
`define CS_OVF_BIT        2
`define CS_CK_LSB         3
`define CS_CK_MSB         4
// field positions of channel_status_reg and output_control_reg
`define CH_CMPF_BIT       0
`define CH_POL_BIT        1
`define OC_OE_BIT         0

`define REG_RESET_VALUE   8'h00
`define CNT_RESET_VALUE   12'h000
`define CNT_TOP_VALUE     12'hfff

// slow mode divides the counter clock input by this ratio
`define SLOW_DIVIDE       32
// base timer timebase period in system cycles (a parameter of the top)
`define TIMEBASE_CYCLES   50000

`endif

// ===== pkg/reload_pwm_pkg.sv
/*
  types for the auto-reload pulse timer.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package reload_pwm_pkg;
    // counter clock sources
    typedef enum logic [1:0] {
        CLK_OFF      = 2'b00,
        CLK_TIMEBASE = 2'b01,
        CLK_CPU      = 2'b10,
        CLK_RESERVED = 2'b11
    } clk_sel_type;
    // low-power modes seen by the timer
    typedef enum logic [1:0] {
        PWR_RUN, PWR_WAIT, PWR_ACTIVE_HALT, PWR_HALT
    } power_mode_type;
    // bus slave phases
    typedef enum logic [0:0] {
        BUS_IDLE, BUS_DATA
    } bus_state_type;
endpackage
`default_nettype wire

// ===== tb/tb_auto_reload_pwm_timer.sv
/*
  directed bench for the auto-reload pulse timer: word-wide AHB-Lite register tasks and
  sequences of register calls with expected values.
  assumes zero-wait-state answers and a timebase shortened to 20 system cycles.
*/
`default_nettype none
`include "reload_pwm_consts.svh"
// compare two values, count and report a mismatch
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_auto_reload_pwm_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;      // system clock, 20 ns
    logic        arst_n = 1'b0;   // asynchronous reset, active low
    logic        hsel = 1'b0;     // bus request lines
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;          // bus answer lines
    logic        hready;
    logic        hresp;
    logic        pulse, oe, ovf_irq, cmp_irq, wake;
    logic [7:0]  rd, r2;          // read-back bytes
    int          n_errors = 0, checks = 0, cycles = 0, hi, per;
    // every register except the power mode register, plus one unmapped word, all zero after reset
    logic [7:0]  reset_idx [10] = '{`IDX_CTRL_STATUS, `IDX_COUNT_HIGH, `IDX_COUNT_LOW,
        `IDX_RELOAD_HIGH, `IDX_RELOAD_LOW, `IDX_OUT_CONTROL, `IDX_CHAN_STATUS,
        `IDX_DUTY_HIGH, `IDX_DUTY_LOW, 8'h14};
    always #10 clk = ~clk;
    reload_pwm_timer #(.TIMEBASE_CYCLES(20)) i_dut (
        .CLK_SYS_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .PULSE_OUTPUT_O(pulse), .PULSE_OE_O(oe), .OVF_IRQ_O(ovf_irq),
        .CMP_IRQ_O(cmp_irq), .WAKE_O(wake));
    // one single transfer; the master never assumes a latency, only the timeout cuts a hang
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {22'h0, idx, 2'h0};
        @(posedge clk); while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0; hwdata <= {24'h0, wd};
        @(posedge clk); while (hready !== 1'b1) @(posedge clk);
        rd = hrdata[7:0];
        `CHK(hresp, 1'b0)
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h0);
        `CHK(rd, exp)
    endtask
    // cycles of one pin period and how many of them are high, from a rising edge
    task automatic meas();
        bit lo;
        lo = 0; hi = 0; per = 0;
        @(posedge pulse);
        forever begin
            @(posedge clk);
            if (pulse === 1'b1 && lo) break;
            lo |= (pulse !== 1'b1); hi += (pulse === 1'b1); per++;
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // cycle ceiling: the sequence needs about five thousand cycles, most of them the first count up to 0xfff
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // every register except the power mode register, and one unmapped word, read zero after reset
        foreach (reset_idx[i])
            rchk(reset_idx[i], 8'h00);
        `CHK({oe, pulse}, 2'b00)
        // reserved clock select must not move the counter
        wr(`IDX_CTRL_STATUS, 8'h18);
        repeat (20) @(posedge clk);
        rchk(`IDX_COUNT_LOW, 8'h00);
        // pulse mode: period 4096-0xff0 = 16, high from 0xff0 up to 0xff8 = 8
        wr(`IDX_RELOAD_HIGH, 8'h0f); wr(`IDX_RELOAD_LOW, 8'hf0);
        wr(`IDX_DUTY_HIGH, 8'h0f); wr(`IDX_DUTY_LOW, 8'hf8);
        wr(`IDX_OUT_CONTROL, 8'h01); wr(`IDX_CTRL_STATUS, 8'h10);
        meas(); meas();
        `CHK(per, 16)
        `CHK(hi, 8)
        `CHK(oe, 1'b1)
        // inverted pin with duty 0xff4: raw high 4, pin high 12 once the shadow loads
        wr(`IDX_CHAN_STATUS, 8'h02); wr(`IDX_DUTY_LOW, 8'hf4);
        meas(); meas();
        `CHK(hi, 12)
        // upper byte alone locks the compare, so the raw pulse never falls
        wr(`IDX_DUTY_HIGH, 8'h0f);
        // let the current period and the pin pipeline pass before counting
        repeat (20) @(posedge clk);
        hi = 0;
        repeat (40) begin @(posedge clk); hi += (pulse === 1'b1); end
        `CHK(hi, 0)
        wr(`IDX_DUTY_LOW, 8'hf4);
        meas(); meas();
        `CHK(hi, 12)
        // active-halt with the cpu clock stops the counter
        // the frozen counter lies between the reload 0xff0 and 0xfff
        wr(`IDX_POWER_MODE, 8'h02); bus(1'b0, `IDX_COUNT_LOW, 8'h0); r2 = rd;
        `CHK(r2[7:4], 4'hf)
        repeat (5) @(posedge clk);
        rchk(`IDX_COUNT_LOW, r2);
        // overflow flag on the timebase clock, wait mode, pin released
        wr(`IDX_CHAN_STATUS, 8'h00); wr(`IDX_OUT_CONTROL, 8'h00);
        wr(`IDX_POWER_MODE, 8'h01); wr(`IDX_CTRL_STATUS, 8'h0a);
        `CHK({oe, pulse}, 2'b00)
        while (ovf_irq !== 1'b1) @(posedge clk);
        @(posedge clk);
        `CHK(wake, 1'b1)
        rchk(`IDX_CTRL_STATUS, 8'h0e);
        rchk(`IDX_CTRL_STATUS, 8'h0e);
        repeat (25) @(posedge clk);
        rchk(`IDX_CTRL_STATUS, 8'h0a);
        `CHK(ovf_irq, 1'b0)
        // compare mode: a zero duty never matches
        wr(`IDX_POWER_MODE, 8'h00); wr(`IDX_CTRL_STATUS, 8'h11);
        wr(`IDX_DUTY_HIGH, 8'h00); wr(`IDX_DUTY_LOW, 8'h00);
        bus(1'b0, `IDX_CHAN_STATUS, 8'h0);
        repeat (40) @(posedge clk);
        rchk(`IDX_CHAN_STATUS, 8'h00);
        wr(`IDX_DUTY_HIGH, 8'h0f); wr(`IDX_DUTY_LOW, 8'hf8);
        repeat (40) @(posedge clk);
        `CHK(cmp_irq, 1'b1)
        wr(`IDX_CTRL_STATUS, 8'h01);
        rchk(`IDX_CHAN_STATUS, 8'h01);
        rchk(`IDX_CHAN_STATUS, 8'h00);
        @(posedge clk); @(posedge clk);
        `CHK(cmp_irq, 1'b0)
        test_done();
    end
endmodule // tb_auto_reload_pwm_timer
`default_nettype wire

// ===== verilog/reload_pwm_timer.sv
/*
  12-bit auto-reload timer with one pulse channel (pulse or output compare), reached as an
  AHB-Lite slave with one register per word, data in the low byte.
  assumes one 50 MHz clock, the power mode set by software through an extra register, and a
  core interrupt controller that takes the two level request outputs.
*/
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
// Notes on behaviour
// - overflow reloads counter, loads shadow duty, output high
// - pulse mode: counter equals shadow duty drives low
// - period is 4096 minus reload counter ticks
// - enable bit drives pulse pin, else released
// - polarity bit inverts the pulse
// - upper duty write suspends compare until lower
// - compare mode uses duty value immediately
// - match sets compare flag, requests enabled interrupt
// - zero duty value disables compare matching
// - every overflow copies duty into shadow register
// - counter starts from zero after reset
// - slow divides by 32; halt stops counter, active-halt too unless timebase clock with overflow irq enabled
// - separate gated requests, wake per power mode
// - clock select field picks off, timebase, cpu
// - overflow flag set on wrap, cleared by read
// - flag stays high one counter tick after clear
// - compare flag cleared by channel status read
// - polarity resets to zero, one inverts
`default_nettype none
`include "reload_pwm_consts.svh"
module reload_pwm_timer
    import reload_pwm_pkg::*;
#(
    parameter int unsigned TIMEBASE_CYCLES = `TIMEBASE_CYCLES
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        ARST_N_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic             PULSE_OUTPUT_O,
    output logic             PULSE_OE_O,
    output logic             OVF_IRQ_O,
    output logic             CMP_IRQ_O,
    output logic             WAKE_O
);
    // control registers
    logic [1:0]  clk_sel;          // counter clock select
    logic        ovf_irq_en;       // overflow_irq_enable
    logic        cmp_irq_en;       // compare_irq_enable
    logic        pulse_en;         // pulse_output_enable
    logic        polarity;         // output_polarity
    logic        slow_mode;        // slow mode: input clock divided by 32
    logic [1:0]  power_mode;       // run, wait, active-halt, halt
    logic [11:0] reload_value;     // reload_value
    logic [11:0] duty_value;       // duty_value as written
    logic [11:0] duty_shadow;      // copy used by pulse mode
    logic        cmp_locked;       // upper byte written, lower pending
    // state
    logic [11:0] counter_value;    // counter_value
    logic        overflow_flag;    // overflow_flag
    logic        ovf_clear_pend;   // clear requested, waits one tick
    logic        compare_flag;     // compare_match_flag
    logic        pulse_raw;        // generated pulse, before polarity
    // bus
    bus_state_type bus_state;
    logic        wr_pend;          // data phase is a write
    logic [7:0]  addr_idx;         // latched register index
    logic        addr_ok;          // latched transfer size was a word

    // word index from a byte address; only aligned words decode
    function automatic logic [7:0] word_index(input logic [31:0] a);
        return (a[1:0] == 2'b00 && a[31:10] == '0) ? a[9:2] : 8'hff;
    endfunction

    // bus address phase: every selected transfer is taken; only whole-word ones reach a register
    wire take = HSEL_I && HREADY_I && HTRANS_I[1];
    wire wr_now = (bus_state == BUS_DATA) && wr_pend && addr_ok;
    wire rd_now = (bus_state == BUS_DATA) && !wr_pend && addr_ok;
    wire [7:0] wbyte = HWDATA_I[7:0];

    // register a request, answer next cycle with zero wait states
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            bus_state <= BUS_IDLE;
            wr_pend   <= 1'b0;
            addr_idx  <= 8'hff;
            addr_ok   <= 1'b0;
        end else begin
            bus_state <= take ? BUS_DATA : BUS_IDLE;
            if (take) begin
                wr_pend  <= HWRITE_I;
                addr_idx <= word_index(HADDR_I);
                addr_ok  <= (HSIZE_I == 3'b010);
            end
        end
    end

    // the slave never stalls and always answers okay
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end
    end

    // counter clock: pick the source, stop it in halt, and in active-halt unless timebase-clocked with overflow irq enabled
    logic base_tick;   // timebase from the base timer divider
    logic slow_tick;   // 1 in 32 of the chosen source
    logic src_pulse;   // raw chosen source
    logic cnt_tick;    // actual counter clock enable
    tick_divider #(.DIVIDE(TIMEBASE_CYCLES)) u_timebase (
        .clk_i    (CLK_SYS_I),
        .arst_n_i (ARST_N_I),
        .en_i     (1'b1),
        .tick_o   (base_tick)
    );
    always_comb begin
        case (clk_sel_type'(clk_sel))
            CLK_TIMEBASE: src_pulse = base_tick;
            CLK_CPU:      src_pulse = 1'b1;
            default:      src_pulse = 1'b0;
        endcase
    end
    tick_divider #(.DIVIDE(`SLOW_DIVIDE)) u_slow (
        .clk_i    (CLK_SYS_I),
        .arst_n_i (ARST_N_I),
        .en_i     (src_pulse),
        .tick_o   (slow_tick)
    );
    // active-halt keeps only the timebase-clocked timer with overflow wake enabled
    wire run_ok = (power_mode == 2'(PWR_RUN)) || (power_mode == 2'(PWR_WAIT)) ||
                  ((power_mode == 2'(PWR_ACTIVE_HALT)) &&
                   (clk_sel == 2'(CLK_TIMEBASE)) && ovf_irq_en);
    // slow tick lags the source by one cycle; acceptable at a 32x slower rate
    assign cnt_tick = run_ok && (slow_mode ? slow_tick : src_pulse);

    wire wrap = cnt_tick && (counter_value == `CNT_TOP_VALUE);
    // compare target: shadow in pulse mode, written value in compare mode
    wire [11:0] cmp_target = pulse_en ? duty_shadow : duty_value;
    wire match = cnt_tick && !wrap && !cmp_locked && (duty_value != 12'h000) &&
                 (counter_value + 12'h001 == cmp_target);

    // counter: upward from zero, reloads on wrap
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            counter_value <= `CNT_RESET_VALUE;
        end else if (wrap) begin
            counter_value <= reload_value;
        end else if (cnt_tick) begin
            counter_value <= counter_value + 12'h001;
        end
    end

    // shadow duty copied on every wrap, even half written
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            duty_shadow <= 12'h000;
        end else if (wrap) begin
            duty_shadow <= duty_value;
        end
    end

    // pulse: high on wrap, low on match in pulse mode
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pulse_raw <= 1'b0;
        end else if (!pulse_en) begin
            pulse_raw <= 1'b0;
        end else if (wrap) begin
            pulse_raw <= 1'b1;
        end else if (match) begin
            pulse_raw <= 1'b0;
        end
    end

    // pin drive and polarity
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            PULSE_OUTPUT_O <= 1'b0;
            PULSE_OE_O     <= 1'b0;
        end else begin
            PULSE_OE_O     <= pulse_en;
            PULSE_OUTPUT_O <= pulse_raw ^ polarity;
        end
    end

    // overflow flag: set on wrap wins; a read clear waits one counter tick
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            overflow_flag  <= 1'b0;
            ovf_clear_pend <= 1'b0;
        end else if (wrap) begin
            overflow_flag  <= 1'b1;
            ovf_clear_pend <= 1'b0;
        end else begin
            if (rd_now && addr_idx == `IDX_CTRL_STATUS && overflow_flag) begin
                ovf_clear_pend <= 1'b1;
            end else if (ovf_clear_pend && cnt_tick) begin
                overflow_flag  <= 1'b0;
                ovf_clear_pend <= 1'b0;
            end
        end
    end

    // compare flag: set on match, cleared by channel status read
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            compare_flag <= 1'b0;
        end else if (match) begin
            compare_flag <= 1'b1;
        end else if (rd_now && addr_idx == `IDX_CHAN_STATUS) begin
            compare_flag <= 1'b0;
        end
    end

    // software-written control registers
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            clk_sel      <= 2'b00;
            ovf_irq_en   <= 1'b0;
            cmp_irq_en   <= 1'b0;
            pulse_en     <= 1'b0;
            polarity     <= 1'b0;
            slow_mode    <= 1'b0;
            power_mode   <= 2'b00;
            reload_value <= 12'h000;
        end else if (wr_now) begin
            case (addr_idx)
                `IDX_CTRL_STATUS: begin
                    clk_sel    <= wbyte[`CS_CK_MSB:`CS_CK_LSB];
                    ovf_irq_en <= wbyte[`CS_OVERFLOW_IRQ_ENABLE_BIT];
                    cmp_irq_en <= wbyte[`CS_COMPARE_IRQ_ENABLE_BIT];
                end
                `IDX_RELOAD_HIGH: reload_value[11:8] <= wbyte[3:0];
                `IDX_RELOAD_LOW:  reload_value[7:0]  <= wbyte;
                `IDX_OUT_CONTROL: pulse_en <= wbyte[`OC_OE_BIT];
                `IDX_CHAN_STATUS: polarity <= wbyte[`CH_POL_BIT];
                `IDX_POWER_MODE: begin
                    power_mode <= wbyte[1:0];
                    slow_mode  <= wbyte[2];
                end
                default: ;
            endcase
        end
    end

    // duty value, locked from upper write to lower write
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            duty_value <= 12'h000;
            cmp_locked <= 1'b0;
        end else if (wr_now && addr_idx == `IDX_DUTY_HIGH) begin
            duty_value[11:8] <= wbyte[3:0];
            cmp_locked       <= 1'b1;
        end else if (wr_now && addr_idx == `IDX_DUTY_LOW) begin
            duty_value[7:0]  <= wbyte;
            cmp_locked       <= 1'b0;
        end
    end

    // read data, registered at the address phase's following edge
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (take && !HWRITE_I) begin
            // a refused size decodes to no register and reads zero
            case ((HSIZE_I == 3'b010) ? word_index(HADDR_I) : 8'hff)
                `IDX_CTRL_STATUS: HRDATA_O <= {27'h0, clk_sel, overflow_flag,
                                               ovf_irq_en, cmp_irq_en};
                `IDX_COUNT_HIGH:  HRDATA_O <= {28'h0, counter_value[11:8]};
                `IDX_COUNT_LOW:   HRDATA_O <= {24'h0, counter_value[7:0]};
                `IDX_RELOAD_HIGH: HRDATA_O <= {28'h0, reload_value[11:8]};
                `IDX_RELOAD_LOW:  HRDATA_O <= {24'h0, reload_value[7:0]};
                `IDX_OUT_CONTROL: HRDATA_O <= {31'h0, pulse_en};
                `IDX_CHAN_STATUS: HRDATA_O <= {30'h0, polarity, compare_flag};
                `IDX_DUTY_HIGH:   HRDATA_O <= {28'h0, duty_value[11:8]};
                `IDX_DUTY_LOW:    HRDATA_O <= {24'h0, duty_value[7:0]};
                `IDX_POWER_MODE:  HRDATA_O <= {29'h0, slow_mode, power_mode};
                default:          HRDATA_O <= 32'h0000_0000;
            endcase
        end
    end

    // interrupt requests and wake, by power mode
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            OVF_IRQ_O <= 1'b0;
            CMP_IRQ_O <= 1'b0;
            WAKE_O    <= 1'b0;
        end else begin
            OVF_IRQ_O <= overflow_flag && ovf_irq_en;
            CMP_IRQ_O <= compare_flag && cmp_irq_en;
            case (power_mode_type'(power_mode))
                PWR_WAIT:        WAKE_O <= (overflow_flag && ovf_irq_en) ||
                                           (compare_flag && cmp_irq_en);
                PWR_ACTIVE_HALT: WAKE_O <= overflow_flag && ovf_irq_en;
                default:         WAKE_O <= 1'b0;
            endcase
        end
    end

    // checks
    a_reload_on_wrap: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        wrap |=> counter_value == $past(reload_value))
        else $error("counter not reloaded on wrap");
    a_shadow_copy: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        wrap |=> duty_shadow == $past(duty_value))
        else $error("shadow not copied on wrap");
    a_pulse_high: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        wrap && pulse_en |=> ##1 PULSE_OUTPUT_O == !polarity)
        else $error("pulse not high after wrap");
    a_pulse_low: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        match && pulse_en && $stable(polarity) |=> ##1
        PULSE_OUTPUT_O == polarity)
        else $error("pulse not low after match");
    a_oe_follow: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        $rose(pulse_en) |=> PULSE_OE_O)
        else $error("pin drive not enabled");
    a_lock_compare: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        cmp_locked |-> !match)
        else $error("compare while duty half written");
    a_zero_duty: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        duty_value == 12'h000 |-> !match)
        else $error("match with zero duty");
    a_cmp_flag_set: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        match |=> compare_flag ##1 (CMP_IRQ_O == $past(cmp_irq_en)))
        else $error("compare flag or request missing");
    a_ovf_set: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        wrap |=> overflow_flag)
        else $error("overflow flag not set");
    a_ovf_hold: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        ovf_clear_pend && !cnt_tick |=> overflow_flag)
        else $error("overflow flag dropped before a tick");
    a_reserved_off: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        clk_sel == 2'b11 || clk_sel == 2'b00 |-> !cnt_tick)
        else $error("counter ticks with clock off");
    a_halt_stop: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        power_mode == 2'(PWR_HALT) && $stable(power_mode) |->
        !cnt_tick && !WAKE_O ##1 !WAKE_O)
        else $error("counter runs in halt");
    c_wrap_pulse: cover property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        wrap && pulse_en);
    c_match: cover property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I) match);
    c_ovf_cleared: cover property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        $fell(overflow_flag));
endmodule // reload_pwm_timer
`default_nettype wire

// ===== verilog/tick_divider.sv
/*
  tick divider: a one-cycle enable pulse every DIVIDE cycles of the clock, counted only
  while the input enable is high.
  assumes one clock and an active-low asynchronous reset.
*/
`default_nettype none
module tick_divider #(
    parameter int unsigned DIVIDE = 32
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic en_i,
    output logic      tick_o
);
    localparam int unsigned W = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
    logic [W-1:0] count;  // enabled cycles since last tick

    // count enables, fire on the last one
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (en_i) begin
                if (count == W'(DIVIDE - 1)) begin
                    count  <= '0;
                    tick_o <= 1'b1;
                end else begin
                    count <= count + W'(1);
                end
            end
        end
    end
endmodule // tick_divider
`default_nettype wire
